// file: inc/dhso_params.svh
// Constants of the directional high-set overcurrent block
`ifndef DHSO_PARAMS_SVH
`define DHSO_PARAMS_SVH
`define DHSO_CUR_W        16
`define DHSO_TMR_W        24
`define DHSO_HYST_NUM     8'h5F
`define DHSO_HYST_DEN     8'h64
`define DHSO_REG_ADDR_W   4
`define DHSO_ADDR_CTRL    4'h0
`define DHSO_ADDR_PH_THR  4'h1
`define DHSO_ADDR_GND_THR 4'h2
`define DHSO_ADDR_PH_DLY  4'h3
`define DHSO_ADDR_GND_DLY 4'h4
`define DHSO_ADDR_PH_DRP  4'h5
`define DHSO_ADDR_GND_DRP 4'h6
`define DHSO_ADDR_ALT_SEL 4'h7
`define DHSO_ADDR_STATUS  4'h8
`define DHSO_ADDR_LOW_CUR 4'h9
`define DHSO_CTRL_GND_SRC 0
`define DHSO_CTRL_DIR     1
`define DHSO_CTRL_MC_INST 2
`define DHSO_CTRL_RST     32'h0000_0000
`define DHSO_THR_RST      32'h0000_FFFF
`define DHSO_DLY_RST      32'h0000_0064
`define DHSO_DRP_RST      32'h0000_0000
`define DHSO_LOW_CUR_RST  32'h0000_0000
`endif

// file: inc/dhso_pkg.sv
// Types of the directional high-set overcurrent block
package dhso_pkg;
	typedef enum logic [1:0] {
		DHSO_IDLE  = 2'b00,
		DHSO_PICK  = 2'b01,
		DHSO_HOLD  = 2'b10
	} dhso_state_t;
endpackage : dhso_pkg

// file: logic/dhso_top.sv
// Directional high-set overcurrent decision logic, phase and ground
// Contract
// R1 - Ground source: measured or residual, by setting
// R2 - Sensitive variant always uses residual current
// R3 - Binary or reclose block suppresses trip; code trips phase instant through reclose block if binary block also on
// R4 - Unblocking while picked up restarts delay
// R5 - Manual close pulse bypasses trip delay
// R6 - Pickup needs current over threshold, direction match
// R7 - Trip when delay expires while picked up
// R8 - Dropout below 95 percent above low current
// R9 - Dropout timer holds pickup, delay keeps running
// R10 - Dropout expiry clears pickup, resets delay
// R11 - Re-exceed cancels dropout, delay continues
// R12 - Delay expiry in dropout trips only if exceeded
// R13 - Re-exceed after expiry in dropout trips at once
// R14 - Manual close instant trips despite binary block
// R15 - Reclose instant request trips despite binary block
// R16 - High-set elements never inrush restrained
// R17 - Alternative setting group switchable at run time
// R18 - Separate pickup and trip outputs per element
// R19 - Phase pickups ORed into one shared timer
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "dhso_params.svh"
module dhso_top #(
	parameter int         CUR_W     = `DHSO_CUR_W,
	parameter int         TMR_W     = `DHSO_TMR_W,
	parameter bit         SENSITIVE = 1'b0
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic [CUR_W-1:0]           i_cur_a,
	input  wire logic [CUR_W-1:0]           i_cur_b,
	input  wire logic [CUR_W-1:0]           i_cur_c,
	input  wire logic [CUR_W-1:0]           i_cur_gnd,
	input  wire logic                       i_dir_ph_fwd,
	input  wire logic                       i_dir_gnd_fwd,
	input  wire logic                       i_blk_ph,
	input  wire logic                       i_blk_gnd,
	input  wire logic                       i_ar_blk_ph,
	input  wire logic                       i_ar_blk_gnd,
	input  wire logic                       i_man_close,
	input  wire logic                       i_reclose_instant_high_set,
	input  wire logic                       i_inrush,
	input  wire logic [`DHSO_REG_ADDR_W-1:0] i_addr,
	input  wire logic [31:0]                i_wdata,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	output logic      [31:0]                o_rdata,
	output logic                            o_ph_pickup,
	output logic      [2:0]                 o_ph_phase_pickup,
	output logic                            o_ph_trip,
	output logic                            o_ground_high_set_pickup,
	output logic                            o_ground_high_set_trip
);
	import dhso_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers (binary and current pins two flops deep; bus pins unsynchronised)
	// ----------------------------------------------------------------
	logic [10:0] sy1;
	logic [10:0] sy2;
	wire  [10:0] pins = {i_dir_ph_fwd, i_dir_gnd_fwd, i_blk_ph, i_blk_gnd, i_ar_blk_ph,
		i_ar_blk_gnd, i_man_close, i_reclose_instant_high_set, i_inrush, 2'b00};
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sy1 <= 11'h000;
			sy2 <= 11'h000;
		end else begin
			sy1 <= pins;
			sy2 <= sy1;
		end
	end
	wire dir_ph   = sy2[10];
	wire dir_gnd  = sy2[9];
	wire blk_bi_p = sy2[8];
	wire blk_bi_g = sy2[7];
	wire blk_ar_p = sy2[6];
	wire blk_ar_g = sy2[5];
	wire mc       = sy2[4];
	wire ar_inst  = sy2[3];
	// Inrush is deliberately unused by high-set elements (see R16)
	wire inrush_unused = sy2[2];

	logic [CUR_W-1:0] ia;
	logic [CUR_W-1:0] ib;
	logic [CUR_W-1:0] ic;
	logic [CUR_W-1:0] ig;
	logic [CUR_W-1:0] ia_s;
	logic [CUR_W-1:0] ib_s;
	logic [CUR_W-1:0] ic_s;
	logic [CUR_W-1:0] ig_s;
	always_ff @(posedge i_clk) begin
		ia_s <= i_cur_a;
		ib_s <= i_cur_b;
		ic_s <= i_cur_c;
		ig_s <= i_cur_gnd;
		ia   <= ia_s;
		ib   <= ib_s;
		ic   <= ic_s;
		ig   <= ig_s;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic [31:0] thr [0:1][0:1];
	logic [31:0] dly [0:1][0:1];
	logic [31:0] drp [0:1][0:1];
	logic [1:0]  alt;
	logic [31:0] low_cur;
	wire         wr_alt = i_wr && (i_addr == `DHSO_ADDR_ALT_SEL);
	// Writes land in the group the alternate bit selects; switching is live
	wire         g = alt[1];
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl    <= `DHSO_CTRL_RST;
			alt     <= 2'b00;
			low_cur <= `DHSO_LOW_CUR_RST;
			for (int k = 0; k < 2; k++) begin
				for (int e = 0; e < 2; e++) begin
					thr[k][e] <= `DHSO_THR_RST;
					dly[k][e] <= `DHSO_DLY_RST;
					drp[k][e] <= `DHSO_DRP_RST;
				end
			end
		end else if (i_wr) begin
			unique case (i_addr)
				`DHSO_ADDR_CTRL:    ctrl          <= i_wdata;
				`DHSO_ADDR_PH_THR:  thr[g][0]     <= i_wdata;
				`DHSO_ADDR_GND_THR: thr[g][1]     <= i_wdata;
				`DHSO_ADDR_PH_DLY:  dly[g][0]     <= i_wdata;
				`DHSO_ADDR_GND_DLY: dly[g][1]     <= i_wdata;
				`DHSO_ADDR_PH_DRP:  drp[g][0]     <= i_wdata;
				`DHSO_ADDR_GND_DRP: drp[g][1]     <= i_wdata;
				`DHSO_ADDR_ALT_SEL: alt           <= i_wdata[1:0];
				`DHSO_ADDR_LOW_CUR: low_cur       <= i_wdata;
				default:            ctrl          <= ctrl;
			endcase
		end
	end
	wire act = alt[0]; // see R17
	wire gnd_src_meas = ctrl[`DHSO_CTRL_GND_SRC];
	wire dir_cfg_fwd  = ctrl[`DHSO_CTRL_DIR];
	wire mc_inst_en   = ctrl[`DHSO_CTRL_MC_INST];

	// ----------------------------------------------------------------
	// Measurement
	// ----------------------------------------------------------------
	function automatic logic over(input logic [CUR_W-1:0] cur, input logic [31:0] t);
		over = {16'h0000, cur} > t;
	endfunction
	// Below 95 percent of pickup, or at or below low current
	function automatic logic under(input logic [CUR_W-1:0] cur, input logic [31:0] t,
		input logic [31:0] lo);
		logic [47:0] lhs;
		logic [47:0] rhs;
		lhs = 48'({cur}) * 48'(`DHSO_HYST_DEN);
		rhs = 48'(t) * 48'(`DHSO_HYST_NUM);
		under = (lhs < rhs) || ({16'h0000, cur} <= lo); // see R8
	endfunction

	// Residual sum, scaled as a plain sum of magnitudes
	wire [CUR_W+1:0] sum3 = {2'b00, ia} + {2'b00, ib} + {2'b00, ic};
	wire [CUR_W-1:0] resid = (sum3 > {2'b00, {CUR_W{1'b1}}}) ? {CUR_W{1'b1}} : sum3[CUR_W-1:0];
	wire [CUR_W-1:0] i_g_op = (!SENSITIVE && gnd_src_meas) ? ig : resid; // see R1 see R2

	wire dir_ok_p = (dir_ph == dir_cfg_fwd); // see R6
	wire dir_ok_g = (dir_gnd == dir_cfg_fwd); // see R6
	wire [2:0] ph_over = {over(ic, thr[act][0]), over(ib, thr[act][0]), over(ia, thr[act][0])};
	wire [2:0] ph_under = {under(ic, thr[act][0], low_cur), under(ib, thr[act][0], low_cur),
		under(ia, thr[act][0], low_cur)};
	logic [2:0] ph_lat;
	wire [2:0] next_ph_lat = dir_ok_p ? ((ph_lat & ~ph_under) | ph_over) : 3'b000;
	always_ff @(posedge i_clk) begin
		if (i_rst) ph_lat <= 3'b000;
		else       ph_lat <= next_ph_lat;
	end
	logic g_lat;
	wire  next_g_lat = dir_ok_g && ((g_lat && !under(i_g_op, thr[act][1], low_cur))
		|| over(i_g_op, thr[act][1]));
	always_ff @(posedge i_clk) begin
		if (i_rst) g_lat <= 1'b0;
		else       g_lat <= next_g_lat;
	end
	wire [1:0] raw = {g_lat, |ph_lat}; // see R19

	// ----------------------------------------------------------------
	// Element state machines
	// ----------------------------------------------------------------
	dhso_state_t st [0:1];
	logic [TMR_W-1:0] dcnt [0:1];
	logic [TMR_W-1:0] hcnt [0:1];
	logic [1:0] expd;
	logic [1:0] blk_q;
	logic [1:0] pu;
	logic [1:0] trip;
	wire  [1:0] blk = {blk_bi_g || blk_ar_g, blk_bi_p || blk_ar_p}; // see R3
	wire  [1:0] bi  = {blk_bi_g, blk_bi_p};
	wire  inst = (mc_inst_en && mc) || ar_inst; // see R14 see R15
	for (genvar e = 0; e < 2; e++) begin : g_el
		wire [TMR_W-1:0] dlyv = dly[act][e][TMR_W-1:0];
		wire [TMR_W-1:0] drpv = drp[act][e][TMR_W-1:0];
		wire active   = (st[e] != DHSO_IDLE);
		wire d_done   = active && (dcnt[e] >= dlyv);
		wire h_done   = (st[e] == DHSO_HOLD) && (hcnt[e] >= drpv);
		wire unblk    = blk_q[e] && !blk[e] && active; // see R4
		// Instant operation overrides binary block; reclose block holds, except on phase with binary block also on
		wire allowed  = !blk[e] || (inst && !(blk[e] && !bi[e] && blk_ar_p && e == 0)
			&& !(e == 1 && blk_ar_g));
		// A stale expired count must not fire in the unblocking cycle
		wire fire     = raw[e] && !unblk && (d_done || expd[e] || (mc && mc_inst_en)
			|| ar_inst); // see R4 see R5
		wire next_trip = fire && allowed; // see R7 see R12 see R13
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				st[e]    <= DHSO_IDLE;
				dcnt[e]  <= '0;
				hcnt[e]  <= '0;
				expd[e]  <= 1'b0;
				blk_q[e] <= 1'b0;
				pu[e]    <= 1'b0;
				trip[e]  <= 1'b0;
			end else begin
				blk_q[e] <= blk[e];
				trip[e]  <= next_trip;
				unique case (st[e])
					DHSO_IDLE: begin
						dcnt[e] <= '0;
						expd[e] <= 1'b0;
						if (raw[e]) st[e] <= DHSO_PICK;
					end
					DHSO_PICK: begin
						if (!raw[e] && drpv != '0) begin
							st[e]   <= DHSO_HOLD; // see R9
							hcnt[e] <= '0;
						end else if (!raw[e]) begin
							st[e]   <= DHSO_IDLE;
						end
					end
					DHSO_HOLD: begin
						hcnt[e] <= hcnt[e] + 1'b1;
						if (raw[e]) st[e] <= DHSO_PICK; // see R11
						else if (h_done) st[e] <= DHSO_IDLE; // see R10
					end
					default: st[e] <= DHSO_IDLE;
				endcase
				if (st[e] != DHSO_IDLE) begin
					if (unblk) begin
						dcnt[e] <= '0;
						expd[e] <= 1'b0;
					end else if (!d_done) dcnt[e] <= dcnt[e] + 1'b1;
					else expd[e] <= 1'b1;
				end
				pu[e] <= next_ph_pu(raw[e], st[e], h_done); // see R18
			end
		end
	end

	function automatic logic next_ph_pu(input logic r, input dhso_state_t s, input logic hd);
		next_ph_pu = r || (s == DHSO_PICK) || (s == DHSO_HOLD && !hd);
	endfunction

	// ----------------------------------------------------------------
	// Outputs and read-back
	// ----------------------------------------------------------------
	wire [31:0] status = {24'h000000, 1'b0, ph_lat, trip, pu};
	wire [31:0] rd_mux =
		(i_addr == `DHSO_ADDR_CTRL)    ? ctrl :
		(i_addr == `DHSO_ADDR_PH_THR)  ? thr[g][0] :
		(i_addr == `DHSO_ADDR_GND_THR) ? thr[g][1] :
		(i_addr == `DHSO_ADDR_PH_DLY)  ? dly[g][0] :
		(i_addr == `DHSO_ADDR_GND_DLY) ? dly[g][1] :
		(i_addr == `DHSO_ADDR_PH_DRP)  ? drp[g][0] :
		(i_addr == `DHSO_ADDR_GND_DRP) ? drp[g][1] :
		(i_addr == `DHSO_ADDR_ALT_SEL) ? {30'h00000000, alt} :
		(i_addr == `DHSO_ADDR_STATUS)  ? status :
		(i_addr == `DHSO_ADDR_LOW_CUR) ? low_cur : 32'h0000_0000;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata                  <= 32'h0000_0000;
			o_ph_pickup              <= 1'b0;
			o_ph_phase_pickup        <= 3'b000;
			o_ph_trip                <= 1'b0;
			o_ground_high_set_pickup <= 1'b0;
			o_ground_high_set_trip   <= 1'b0;
		end else begin
			o_rdata                  <= i_rd ? rd_mux : 32'h0000_0000;
			o_ph_pickup              <= pu[0];
			o_ph_phase_pickup        <= ph_lat;
			o_ph_trip                <= trip[0];
			o_ground_high_set_pickup <= pu[1];
			o_ground_high_set_trip   <= trip[1];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_blocked_no_trip; // see R3
		@(posedge i_clk) disable iff (i_rst) (blk[0] && !inst) |=> !trip[0];
	endproperty
	a_blocked_no_trip: assert property (p_blocked_no_trip) else $error("Blocked phase tripped");
	property p_trip_needs_pick; // see R7
		@(posedge i_clk) disable iff (i_rst) $rose(trip[1]) |-> $past(raw[1]);
	endproperty
	a_trip_needs_pick: assert property (p_trip_needs_pick) else $error("Trip without pickup");
	property p_unblock_restart; // see R4
		@(posedge i_clk) disable iff (i_rst) (g_el[0].unblk) |=> (dcnt[0] == '0);
	endproperty
	a_unblock_restart: assert property (p_unblock_restart) else $error("Delay not restarted");
	property p_hold_keeps_pu; // see R9
		@(posedge i_clk) disable iff (i_rst) (st[0] == DHSO_HOLD && !g_el[0].h_done) |=> pu[0];
	endproperty
	a_hold_keeps_pu: assert property (p_hold_keeps_pu) else $error("Hold lost pickup");
	property p_hold_end; // see R10
		@(posedge i_clk) disable iff (i_rst)
			(g_el[1].h_done && !raw[1]) |=> (st[1] == DHSO_IDLE) ##1 (dcnt[1] == '0);
	endproperty
	a_hold_end: assert property (p_hold_end) else $error("Dropout end did not reset");
	property p_instant; // see R14
		@(posedge i_clk) disable iff (i_rst)
			(mc && mc_inst_en && raw[0] && !blk_ar_p) |=> trip[0];
	endproperty
	a_instant: assert property (p_instant) else $error("Manual close did not trip");
	property p_reclose_inst; // see R15
		@(posedge i_clk) disable iff (i_rst) (ar_inst && raw[1] && !blk_ar_g) |=> trip[1];
	endproperty
	a_reclose_inst: assert property (p_reclose_inst) else $error("Reclose instant missed");
	property p_pick_dir; // see R6
		@(posedge i_clk) disable iff (i_rst) !dir_ok_g |=> !g_lat;
	endproperty
	a_pick_dir: assert property (p_pick_dir) else $error("Pickup against direction");
endmodule : dhso_top

// file: dv/dhso_front_model.sv
// Model of the measurement and direction front end feeding the block
`timescale 1ns/10ps
module dhso_front_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_amp_a,
	input  wire logic [15:0] i_amp_b,
	input  wire logic [15:0] i_amp_c,
	input  wire logic [15:0] i_amp_g,
	input  wire logic        i_fwd_ph,
	input  wire logic        i_fwd_gnd,
	output logic      [15:0] o_cur_a,
	output logic      [15:0] o_cur_b,
	output logic      [15:0] o_cur_c,
	output logic      [15:0] o_cur_g,
	output logic             o_dir_ph,
	output logic             o_dir_gnd
);
	// One sample of measurement latency, as a real converter has
	always_ff @(posedge i_clk) begin
		o_cur_a   <= i_amp_a;
		o_cur_b   <= i_amp_b;
		o_cur_c   <= i_amp_c;
		o_cur_g   <= i_amp_g;
		o_dir_ph  <= i_fwd_ph;
		o_dir_gnd <= i_fwd_gnd;
	end
endmodule : dhso_front_model

// file: dv/directional_high_set_overcurrent_tb.sv
// Self-checking bench of the directional high-set overcurrent block
`timescale 1ns/10ps
`include "dhso_params.svh"
module directional_high_set_overcurrent_tb;
	logic        i_clk, i_rst, i_wr, i_rd, blk, man, recl, fwd, fwdg;
	logic [3:0]  i_addr;
	logic [31:0] i_wdata, o_rdata;
	logic [15:0] a, b, c, g, ca, cb, cc, cg;
	logic        dp, dg, o_ph_pickup, o_ph_trip, o_gpu, o_gtrip;
	logic [2:0]  o_ph_phase_pickup;
	int          err_total, samples_checked;
	dhso_front_model u_fe (.i_clk(i_clk), .i_amp_a(a), .i_amp_b(b), .i_amp_c(c), .i_amp_g(g),
		.i_fwd_ph(fwd), .i_fwd_gnd(fwdg), .o_cur_a(ca), .o_cur_b(cb), .o_cur_c(cc),
		.o_cur_g(cg), .o_dir_ph(dp), .o_dir_gnd(dg));
	dhso_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cur_a(ca), .i_cur_b(cb), .i_cur_c(cc),
		.i_cur_gnd(cg), .i_dir_ph_fwd(dp), .i_dir_gnd_fwd(dg), .i_blk_ph(blk),
		.i_blk_gnd(1'b0), .i_ar_blk_ph(1'b0), .i_ar_blk_gnd(1'b0), .i_man_close(man),
		.i_reclose_instant_high_set(recl), .i_inrush(1'b1), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_ph_pickup(o_ph_pickup), .o_ph_phase_pickup(o_ph_phase_pickup),
		.o_ph_trip(o_ph_trip), .o_ground_high_set_pickup(o_gpu),
		.o_ground_high_set_trip(o_gtrip));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	function automatic logic outv(input int w);
		case (w)
			0: outv = o_ph_pickup;
			1: outv = o_ph_trip;
			2: outv = o_gpu;
			default: outv = o_gtrip;
		endcase
	endfunction : outv
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// Output w reaches v no sooner than lo and no later than hi cycles
	task automatic win(input int w, input logic v, input int lo, input int hi);
		int k;
		for (k = 1; k <= hi; k++) begin
			@(posedge i_clk);
			#1;
			if (outv(w) === v) break;
		end
		cmp(32'(k >= lo && k <= hi), 32'h1);
	endtask : win
	task automatic stay(input int w, input logic v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			@(posedge i_clk);
			#1;
			if (outv(w) !== v) bad = 1'b1;
		end
		cmp(32'(bad), 32'h0);
	endtask : stay
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge i_clk);
		i_addr  <= ad;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr    <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [3:0] ad, input logic [31:0] exp);
		@(posedge i_clk);
		i_addr <= ad;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd   <= 1'b0;
		#1;
		cmp(o_rdata, exp);
	endtask : rdc
	// Long settle so a running dropout hold has expired too
	task automatic quiet_all();
		@(posedge i_clk);
		{a, b, c, g} <= 64'h0;
		{blk, man, recl} <= 3'h0;
		repeat (80) @(posedge i_clk);
	endtask : quiet_all
	task automatic t_regs();
		rdc(`DHSO_ADDR_CTRL, `DHSO_CTRL_RST);
		rdc(`DHSO_ADDR_PH_THR, `DHSO_THR_RST);
		rdc(`DHSO_ADDR_GND_DLY, `DHSO_DLY_RST);
		rdc(`DHSO_ADDR_GND_DRP, `DHSO_DRP_RST);
		rdc(4'hF, 32'h0);
		wr(`DHSO_ADDR_PH_THR, 32'h0000_03E8);
		rdc(`DHSO_ADDR_PH_THR, 32'h0000_03E8);
		wr(`DHSO_ADDR_CTRL, 32'h0000_0002);
		wr(`DHSO_ADDR_GND_THR, 32'h0000_01F4);
		wr(`DHSO_ADDR_PH_DLY, 32'h0000_0028);
		wr(`DHSO_ADDR_GND_DLY, 32'h0000_0028);
	endtask : t_regs
	task automatic t_pick();
		fwd  <= 1'b0;
		fwdg <= 1'b0;
		a    <= 16'h07D0;
		stay(0, 1'b0, 25);
		fwd <= 1'b1;
		win(1, 1'b1, 40, 65);
		cmp(32'({o_ph_pickup, o_ph_phase_pickup, o_gpu, o_gtrip}), 32'h24);
		a <= 16'h03CA;
		stay(0, 1'b1, 20);
		a <= 16'h03AC;
		win(0, 1'b0, 1, 20);
	endtask : t_pick
	task automatic t_block();
		quiet_all();
		blk <= 1'b1;
		c   <= 16'h07D0;
		stay(1, 1'b0, 70);
		cmp(32'(o_ph_phase_pickup), 32'h4);
		blk <= 1'b0;
		win(1, 1'b1, 40, 65);
	endtask : t_block
	task automatic t_instant(input logic [31:0] ctrl, input bit by_close);
		quiet_all();
		wr(`DHSO_ADDR_CTRL, ctrl);
		blk <= 1'b1;
		b   <= 16'h07D0;
		repeat (15) @(posedge i_clk);
		if (by_close) man <= 1'b1;
		else recl <= 1'b1;
		win(1, 1'b1, 1, 15);
	endtask : t_instant
	task automatic t_gnd();
		quiet_all();
		wr(`DHSO_ADDR_CTRL, 32'h0000_0003);
		fwdg <= 1'b1;
		g    <= 16'h03E8;
		win(2, 1'b1, 1, 20);
		cmp(32'(o_ph_pickup), 32'h0);
		wr(`DHSO_ADDR_CTRL, 32'h0000_0002);
		win(2, 1'b0, 1, 20);
		a <= 16'h0258;
		win(2, 1'b1, 1, 20);
	endtask : t_gnd
	task automatic t_drop();
		quiet_all();
		wr(`DHSO_ADDR_GND_DRP, 32'h0000_001E);
		wr(`DHSO_ADDR_CTRL, 32'h0000_0003);
		g <= 16'h03E8;
		repeat (20) @(posedge i_clk);
		g <= 16'h0;
		stay(2, 1'b1, 10);
		g <= 16'h03E8;
		win(3, 1'b1, 5, 25);
		quiet_all();
		g <= 16'h03E8;
		repeat (20) @(posedge i_clk);
		g <= 16'h0;
		stay(3, 1'b0, 45);
		cmp(32'(o_gpu), 32'h0);
	endtask : t_drop
	task automatic wrap_up();
		if (err_total == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		{i_rst, i_wr, i_rd, blk, man, recl, fwd, fwdg} = 8'h81;
		{a, b, c, g, i_addr, i_wdata} = 100'h0;
		err_total = 0;
		samples_checked = 0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_pick();
		t_block();
		t_instant(32'h0000_0006, 1'b1);
		t_instant(32'h0000_0002, 1'b0);
		t_gnd();
		t_drop();
		wrap_up();
	end
	// Run needs about 900 cycles
	initial begin
		#50000;
		err_total++;
		wrap_up();
	end
endmodule : directional_high_set_overcurrent_tb
